/* File: rtl/eu_pkg.sv */
package eu_pkg;
  // vector numbers of the fixed table slots
  localparam logic [5:0] VEC_SP   = 6'h00;
  localparam logic [5:0] VEC_RST  = 6'h01;
  localparam logic [5:0] VEC_NMI  = 6'h02;
  localparam logic [5:0] VEC_HF   = 6'h03;
  localparam logic [5:0] VEC_MEM  = 6'h04;
  localparam logic [5:0] VEC_BUS  = 6'h05;
  localparam logic [5:0] VEC_USG  = 6'h06;
  localparam logic [5:0] VEC_SVC  = 6'h0B;
  localparam logic [5:0] VEC_MON  = 6'h0C;
  localparam logic [5:0] VEC_PSV  = 6'h0E;
  localparam logic [5:0] VEC_TICK = 6'h0F;
  localparam int         VEC_IRQ0 = 16;
  localparam int         PRI_W    = 3;
  // internal ranks, lower wins; programmable value p ranks as RANK_PROG + p
  localparam logic [3:0] RANK_NMI  = 4'h1;
  localparam logic [3:0] RANK_HF   = 4'h2;
  localparam logic [3:0] RANK_PROG = 4'h3;
  localparam logic [3:0] RANK_IDLE = 4'hF;
  localparam logic [2:0] PRI_RST   = 3'h0;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_SHCTRL  = 8'h04;
  localparam logic [7:0] ADR_ENSET   = 8'h08;
  localparam logic [7:0] ADR_ENCLR   = 8'h0C;
  localparam logic [7:0] ADR_PNDSET  = 8'h10;
  localparam logic [7:0] ADR_PNDCLR  = 8'h14;
  localparam logic [7:0] ADR_ACTIVE  = 8'h18;
  localparam logic [7:0] ADR_GROUP   = 8'h1C;
  localparam logic [7:0] ADR_SYSPRI0 = 8'h20;
  localparam logic [7:0] ADR_SYSPRI1 = 8'h24;
  localparam logic [7:0] ADR_PRI0    = 8'h40;
  // control register write bits
  localparam int CTRL_NMI_SET  = 0;
  localparam int CTRL_PSV_SET  = 1;
  localparam int CTRL_PSV_CLR  = 2;
  localparam int CTRL_TICK_SET = 3;
  localparam int CTRL_TICK_CLR = 4;
  // handler control bits
  localparam int SH_MEM_EN = 0;
  localparam int SH_BUS_EN = 1;
  localparam int SH_USG_EN = 2;
  localparam int SH_MON_EN = 3;
  localparam int SH_UNAL   = 4;
  localparam int SH_DIV0   = 5;
  localparam logic [5:0] SH_RST = 6'h00;

  typedef struct packed {
    logic instr_done;     // an instruction retired
    logic stack_done;     // state push finished
    logic fetch_done;     // vector word fetched
    logic unstack_done;   // state pop finished
    logic exc_return;     // handler executed its return
    logic exc_err;        // error during exception processing
    logic mpu_fault;      // protection violation or region miss
    logic xn_fetch;       // fetch from an execute-never region
    logic bus_precise;    // precise bus error
    logic bus_imprecise;  // imprecise bus error
    logic usage_fault;    // undefined, illegal unaligned, bad state, bad return
    logic unaligned;      // unaligned word or halfword access
    logic div_zero;       // divide by zero
    logic supervisor_call;            // supervisor call executed
    logic mon_req;        // debug monitor event
    logic halting;        // debugger halting
    logic tick_zero;      // system timer reached zero
    logic tick_int_en;    // system timer interrupt enabled
  } eu_core_ev_t;

  typedef struct packed {
    logic        stack_req;    // push state, held until stack_done
    logic        unstack_req;  // pop state, held until unstack_done
    logic        fetch_req;    // read table word, held until fetch_done
    logic [31:0] fetch_addr;   // table address, vector times four
    logic        load_sp;      // fetched word is the initial stack pointer
    logic        handler;      // handler mode
    logic        priv_thread;  // privileged thread mode after reset
    logic [5:0]  cur_vec;      // running exception vector
  } eu_core_cmd_t;

  typedef enum logic [2:0] {
    ST_RST_SP  = 3'b000,
    ST_RST_PC  = 3'b001,
    ST_RUN     = 3'b010,
    ST_ENTRY   = 3'b011,
    ST_RET     = 3'b100,
    ST_UNSTACK = 3'b101
  } eu_state_t;
endpackage

/* File: rtl/eu_exc_ctrl.sv */
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
module eu_exc_ctrl
  import eu_pkg::*;
#(
  parameter int NUM_IRQ = 32
) (
  input  wire logic        i_sys_clk,  // processor clock
  input  wire logic        i_nrst,     // async reset, active low
  input  wire logic        i_wb_cyc,   // wishbone cycle
  input  wire logic        i_wb_stb,   // wishbone strobe
  input  wire logic        i_wb_we,    // wishbone write
  input  wire logic [7:0]  i_wb_adr,   // byte address
  input  wire logic [31:0] i_wb_dat,   // write data
  input  wire logic [3:0]  i_wb_sel,   // byte enables
  output logic      [31:0] o_wb_dat,   // read data
  output logic             o_wb_ack,   // acknowledge
  input  wire logic        i_nmi,      // nmi pin, asynchronous
  input  wire logic [NUM_IRQ-1:0] i_irq,  // peripheral requests, same clock
  input  wire eu_core_ev_t i_core,     // core events, same clock
  output eu_core_cmd_t     o_core      // commands to the core
);
  localparam int NV = VEC_IRQ0 + NUM_IRQ;

  if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_chk
    $error("NUM_IRQ must be 1 to 32");
  end

  logic [PRI_W-1:0] pri_reg [NV];
  logic [NUM_IRQ-1:0] en_irq_reg;
  logic [5:0]  sh_reg;
  logic [1:0]  grp_reg;
  logic [NV-1:0] pend_reg;
  logic [NV-1:0] act_reg;
  logic [NV-1:0] pend_set;
  logic [NV-1:0] pend_clr;
  logic [NV-1:0] act_clr;
  logic [NV-1:0] en_vec;
  logic [3:0]  full_rk [NV];
  logic [3:0]  pre_rk [NV];
  logic [3:0]  best_rank;
  logic [5:0]  best_vec;
  logic        best_hit;
  logic [3:0]  cur_pre;
  logic [5:0]  cur_vec;
  logic        nmi_s1_reg;
  logic        nmi_s2_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] pri_rd;
  logic [10:0] slot_tab [NV];
  eu_state_t   st_reg;
  eu_state_t   st_next;
  eu_core_cmd_t cmd_reg;
  eu_core_cmd_t cmd_next;

  // bus decode; one request per ack, ack clears the next cycle
  wire        bus_req  = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire        bus_wr   = bus_req & i_wb_we;
  wire [31:0] bmask    = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] wd       = i_wb_dat & bmask;
  wire        wr_ctrl  = bus_wr & (i_wb_adr == ADR_CTRL);
  wire        wr_sh    = bus_wr & (i_wb_adr == ADR_SHCTRL);
  wire        wr_eset  = bus_wr & (i_wb_adr == ADR_ENSET);
  wire        wr_eclr  = bus_wr & (i_wb_adr == ADR_ENCLR);
  wire        wr_pset  = bus_wr & (i_wb_adr == ADR_PNDSET);
  wire        wr_pclr  = bus_wr & (i_wb_adr == ADR_PNDCLR);
  wire        wr_grp   = bus_wr & (i_wb_adr == ADR_GROUP) & i_wb_sel[0];
  wire [2:0]  grp_mask = 3'(3'h7 << grp_reg);

  // priority slot of vector v: {programmable, address, byte lane}
  function automatic logic [10:0] pri_slot(input int v);
    logic [7:0] a;
    a = 8'(ADR_PRI0 + 4 * ((v - VEC_IRQ0) / 4));
    if (v >= VEC_IRQ0)
      return {1'b1, a, 2'(v % 4)};
    case (v)
      4:       return {1'b1, ADR_SYSPRI0, 2'h0};
      5:       return {1'b1, ADR_SYSPRI0, 2'h1};
      6:       return {1'b1, ADR_SYSPRI0, 2'h2};
      11:      return {1'b1, ADR_SYSPRI0, 2'h3};
      12:      return {1'b1, ADR_SYSPRI1, 2'h0};
      14:      return {1'b1, ADR_SYSPRI1, 2'h1};
      15:      return {1'b1, ADR_SYSPRI1, 2'h2};
      default: return 11'h000;
    endcase
  endfunction

  // slot table held in named wires, since a function result cannot be bit-selected
  always_comb
  begin
    for (int v = 0; v < NV; v++)
      slot_tab[v] = pri_slot(v);
  end

  // priority storage, three bits in the low end of each byte lane
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    for (int v = 0; v < NV; v++)
    begin
      if (!i_nrst)
        pri_reg[v] <= PRI_RST;
      else if (bus_wr && slot_tab[v][10] && i_wb_adr == slot_tab[v][9:2]
               && i_wb_sel[slot_tab[v][1:0]])
        pri_reg[v] <= i_wb_dat[8 * slot_tab[v][1:0] +: PRI_W];
    end
  end

  // rank tables; fixed priorities sit above every programmable value
  always_comb
  begin
    for (int v = 0; v < NV; v++)
    begin
      full_rk[v] = RANK_PROG + {1'b0, pri_reg[v]};
      pre_rk[v] = RANK_PROG + {1'b0, pri_reg[v] & grp_mask};
    end
    full_rk[VEC_NMI] = RANK_NMI;
    pre_rk[VEC_NMI] = RANK_NMI;
    full_rk[VEC_HF] = RANK_HF;
    pre_rk[VEC_HF] = RANK_HF;
  end

  // enable gating; a disabled exception still keeps its pending bit
  always_comb
  begin
    en_vec = '1;
    en_vec[VEC_MEM] = sh_reg[SH_MEM_EN];
    en_vec[VEC_BUS] = sh_reg[SH_BUS_EN];
    en_vec[VEC_USG] = sh_reg[SH_USG_EN];
    en_vec[VEC_MON] = sh_reg[SH_MON_EN];
    en_vec[NV-1:VEC_IRQ0] = en_irq_reg;
  end

  // best pending: strict compare in ascending order keeps lower vector on ties
  always_comb
  begin
    best_rank = RANK_IDLE;
    best_vec = VEC_SP;
    best_hit = 1'b0;
    cur_pre = RANK_IDLE;
    cur_vec = VEC_SP;
    for (int v = 0; v < NV; v++)
    begin
      if (pend_reg[v] && en_vec[v] && full_rk[v] < best_rank)
      begin
        best_rank = full_rk[v];
        best_vec = 6'(v);
        best_hit = 1'b1;
      end
      if (act_reg[v] && pre_rk[v] < cur_pre)
      begin
        cur_pre = pre_rk[v];
        cur_vec = 6'(v);
      end
    end
  end

  wire [3:0] best_pre = pre_rk[best_vec];
  wire       preempt  = best_hit & (best_pre < cur_pre);
  // synchronous causes enter at once; asynchronous ones at an instruction boundary
  wire       sync_best = (best_vec == VEC_HF) | (best_vec == VEC_MEM) | (best_vec == VEC_BUS)
                       | (best_vec == VEC_USG) | (best_vec == VEC_SVC) | (best_vec == VEC_MON);
  wire       run_take  = (st_reg == ST_RUN) & preempt & ~i_core.exc_return
                       & (i_core.instr_done | sync_best);
  wire       ret_take  = (st_reg == ST_RET) & preempt;
  wire       take      = run_take | ret_take;
  wire       go_unstk  = (st_reg == ST_RET) & ~preempt;
  wire       ret_now   = (st_reg == ST_RUN) & i_core.exc_return & (|act_reg);

  // fault causes; a fault that cannot be taken, other than an enabled imprecise bus error, escalates to hard fault
  wire mem_c  = i_core.mpu_fault | i_core.xn_fetch;
  wire bus_c  = i_core.bus_precise | i_core.bus_imprecise;
  wire usg_c  = i_core.usage_fault | (i_core.unaligned & sh_reg[SH_UNAL])
              | (i_core.div_zero & sh_reg[SH_DIV0]);
  wire mem_ok = sh_reg[SH_MEM_EN] & (pre_rk[VEC_MEM] < cur_pre);
  wire bus_ok = sh_reg[SH_BUS_EN] & (i_core.bus_imprecise | (pre_rk[VEC_BUS] < cur_pre));
  wire usg_ok = sh_reg[SH_USG_EN] & (pre_rk[VEC_USG] < cur_pre);
  wire svc_ok = pre_rk[VEC_SVC] < cur_pre;
  wire hf_set = i_core.exc_err | (mem_c & ~mem_ok) | (bus_c & ~bus_ok)
              | (usg_c & ~usg_ok) | (i_core.supervisor_call & ~svc_ok);

  // pending sources; vectors 0, 1, 7 to 10 and 13 never pend
  always_comb
  begin
    pend_set = '0;
    pend_set[VEC_NMI] = nmi_s2_reg | (wr_ctrl & wd[CTRL_NMI_SET]);
    pend_set[VEC_HF] = hf_set;
    pend_set[VEC_MEM] = mem_c & mem_ok;
    pend_set[VEC_BUS] = bus_c & bus_ok;
    pend_set[VEC_USG] = usg_c & usg_ok;
    pend_set[VEC_SVC] = i_core.supervisor_call & svc_ok;
    pend_set[VEC_MON] = i_core.mon_req & sh_reg[SH_MON_EN] & ~i_core.halting;
    pend_set[VEC_PSV] = wr_ctrl & wd[CTRL_PSV_SET];
    pend_set[VEC_TICK] = (i_core.tick_zero & i_core.tick_int_en)
                       | (wr_ctrl & wd[CTRL_TICK_SET]);
    pend_set[NV-1:VEC_IRQ0] = i_irq | (wr_pset ? wd[NUM_IRQ-1:0] : '0);
  end

  // pending clears: entry of the handler, or software
  always_comb
  begin
    pend_clr = '0;
    if (take)
      pend_clr[best_vec] = 1'b1;
    pend_clr[VEC_PSV] = pend_clr[VEC_PSV] | (wr_ctrl & wd[CTRL_PSV_CLR]);
    pend_clr[VEC_TICK] = pend_clr[VEC_TICK] | (wr_ctrl & wd[CTRL_TICK_CLR]);
    pend_clr[NV-1:VEC_IRQ0] = pend_clr[NV-1:VEC_IRQ0] | (wr_pclr ? wd[NUM_IRQ-1:0] : '0);
    act_clr = '0;
    if (ret_now)
      act_clr[cur_vec] = 1'b1;
  end

  // state bits; set beats clear, so a source still high re-pends (active and pending)
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pend_reg <= '0;
      act_reg <= '0;
    end
    else
    begin
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      act_reg <= (act_reg & ~act_clr) | (take ? (NV'(1) << best_vec) : '0);
    end
  end

  // control registers; nmi pin passes two flops first
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      en_irq_reg <= '0;
      sh_reg <= SH_RST;
      grp_reg <= 2'h0;
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
    end
    else
    begin
      en_irq_reg <= (en_irq_reg | (wr_eset ? wd[NUM_IRQ-1:0] : '0))
                  & ~(wr_eclr ? wd[NUM_IRQ-1:0] : '0);
      if (wr_sh)
        sh_reg <= (sh_reg & ~bmask[5:0]) | wd[5:0];
      if (wr_grp)
        grp_reg <= i_wb_dat[1:0];
      nmi_s1_reg <= i_nmi;
      nmi_s2_reg <= nmi_s1_reg;
    end
  end

  // sequencer
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ST_RST_SP:  if (i_core.fetch_done) st_next = ST_RST_PC;
      ST_RST_PC:  if (i_core.fetch_done) st_next = ST_RUN;
      ST_RUN:     if (run_take) st_next = ST_ENTRY;
                  else if (ret_now) st_next = ST_RET;
      ST_ENTRY:   if (~cmd_next.stack_req & ~cmd_next.fetch_req) st_next = ST_RUN;
      ST_RET:     st_next = preempt ? ST_ENTRY : ST_UNSTACK;
      ST_UNSTACK: if (~cmd_next.unstack_req) st_next = ST_RUN;
      default:    st_next = ST_RST_SP;
    endcase
  end

  // core commands: requests hold until their done pulse
  always_comb
  begin
    cmd_next = cmd_reg;
    cmd_next.stack_req = (cmd_reg.stack_req & ~i_core.stack_done) | run_take;
    cmd_next.fetch_req = (cmd_reg.fetch_req & ~i_core.fetch_done) | take
                       | ((st_reg == ST_RST_SP) & i_core.fetch_done);
    cmd_next.unstack_req = (cmd_reg.unstack_req & ~i_core.unstack_done) | go_unstk;
    if (take)
      cmd_next.fetch_addr = {24'h000000, best_vec, 2'h0};
    else if ((st_reg == ST_RST_SP) & i_core.fetch_done)
      cmd_next.fetch_addr = {24'h000000, VEC_RST, 2'h0};
    cmd_next.load_sp = (st_next == ST_RST_SP);
    cmd_next.handler = |((act_reg & ~act_clr) | (take ? (NV'(1) << best_vec) : '0));
    cmd_next.priv_thread = (st_next != ST_RST_SP) & (st_next != ST_RST_PC) & ~cmd_next.handler;
    cmd_next.cur_vec = cur_vec;
  end

  // reset holds the core at the stack pointer fetch from vector 0
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_reg <= ST_RST_SP;
      cmd_reg <= '{stack_req: 1'b0, unstack_req: 1'b0, fetch_req: 1'b1,
                   fetch_addr: 32'h0000_0000, load_sp: 1'b1, handler: 1'b0,
                   priv_thread: 1'b0, cur_vec: 6'h00};
    end
    else
    begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
    end
  end

  // priority read-back per byte lane
  always_comb
  begin
    pri_rd = 32'h0000_0000;
    for (int v = 0; v < NV; v++)
      if (slot_tab[v][10] && i_wb_adr == slot_tab[v][9:2])
        pri_rd[8 * slot_tab[v][1:0] +: PRI_W] = pri_reg[v];
  end

  wire [31:0] ctrl_rd = {15'h0, best_hit, 2'h0, best_vec, 2'h0, cur_vec};
  wire [31:0] rd_mux  = (i_wb_adr == ADR_CTRL)   ? ctrl_rd :
                        (i_wb_adr == ADR_SHCTRL) ? {26'h0, sh_reg} :
                        (i_wb_adr == ADR_ENSET || i_wb_adr == ADR_ENCLR) ? 32'(en_irq_reg) :
                        (i_wb_adr == ADR_PNDSET || i_wb_adr == ADR_PNDCLR)
                          ? 32'(pend_reg[NV-1:VEC_IRQ0]) :
                        (i_wb_adr == ADR_ACTIVE) ? 32'(act_reg[NV-1:VEC_IRQ0]) :
                        (i_wb_adr == ADR_GROUP)  ? {30'h0, grp_reg} : pri_rd;

  // bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req && !i_wb_we)
        dat_reg <= rd_mux;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = dat_reg;
  assign o_core   = cmd_reg;

  property p_rst_sp;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    st_reg == ST_RST_SP |-> o_core.fetch_req && o_core.load_sp && o_core.fetch_addr == 32'h0;
  endproperty
  a_rst_sp: assert property (p_rst_sp) else $error("sp fetch not from entry 0");

  property p_rst_pc;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    st_reg == ST_RST_SP && i_core.fetch_done |=> o_core.fetch_addr == 32'h4 && !o_core.load_sp;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("reset vector not fetched");

  property p_entry;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    run_take |=> o_core.stack_req && o_core.fetch_req
                 && o_core.fetch_addr == {24'h000000, $past(best_vec), 2'h0};
  endproperty
  a_entry: assert property (p_entry) else $error("entry without stack and fetch");

  property p_tail;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ret_take |=> !o_core.unstack_req && !o_core.stack_req && o_core.fetch_req;
  endproperty
  a_tail: assert property (p_tail) else $error("tail chain restacked");

  property p_active;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    take |=> act_reg[$past(best_vec)] ##1 o_core.handler;
  endproperty
  a_active: assert property (p_active) else $error("taken vector not active");

  property p_irq_pend;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_irq[0] |=> pend_reg[VEC_IRQ0];
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("request did not pend");

  property p_nmi_best;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    pend_reg[VEC_NMI] |-> best_hit && best_vec == VEC_NMI;
  endproperty
  a_nmi_best: assert property (p_nmi_best) else $error("nmi outranked");

  property p_hf;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_core.exc_err |=> pend_reg[VEC_HF] || act_reg[VEC_HF];
  endproperty
  a_hf: assert property (p_hf) else $error("hard fault not raised");

  property p_mon;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !pend_reg[VEC_MON] && !(i_core.mon_req && sh_reg[SH_MON_EN] && !i_core.halting)
    |=> !pend_reg[VEC_MON];
  endproperty
  a_mon: assert property (p_mon) else $error("monitor pended while off");

  property p_psv;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !pend_reg[VEC_PSV] && !(wr_ctrl && i_wb_dat[CTRL_PSV_SET] && i_wb_sel[0])
    |=> !pend_reg[VEC_PSV];
  endproperty
  a_psv: assert property (p_psv) else $error("service request pended by hardware");

  property p_strict;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    st_reg == ST_RUN && best_hit && best_pre >= cur_pre && !cmd_reg.stack_req
    |=> !o_core.stack_req;
  endproperty
  a_strict: assert property (p_strict) else $error("preempted at equal level");
endmodule

/* File: test/eu_core_model.sv */
`timescale 1ns/100ps
// core stand-in: acknowledges push, pop and table reads after LAT cycles
module eu_core_model
  import eu_pkg::*;
#(
  parameter int LAT = 2
) (
  input  wire logic         i_sys_clk,  // processor clock
  input  wire logic         i_nrst,     // async reset, active low
  input  wire eu_core_cmd_t i_cmd,      // commands from the controller
  input  wire eu_core_ev_t  i_tb_ev,    // events the bench injects
  output eu_core_ev_t       o_ev        // merged event bus
);
  logic [3:0] wait_reg;
  logic       instr_reg;
  logic       busy;
  logic       hit;
  // one shared latency counter; push and fetch issued together finish together
  assign busy = i_cmd.stack_req | i_cmd.unstack_req | i_cmd.fetch_req;
  assign hit  = busy && (wait_reg == LAT[3:0]);
  // restart after each acknowledge so a held request is never acked twice at once
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wait_reg  <= 4'h0;
      instr_reg <= 1'b0;
    end
    else
    begin
      wait_reg  <= (hit || !busy) ? 4'h0 : wait_reg + 4'h1;
      instr_reg <= ~instr_reg;  // a retire every other cycle delays async entry
    end
  end
  // done pulses laid over the bench's own events
  always_comb
  begin
    o_ev              = i_tb_ev;
    o_ev.instr_done   = instr_reg;
    o_ev.stack_done   = hit & i_cmd.stack_req;
    o_ev.fetch_done   = hit & i_cmd.fetch_req;
    o_ev.unstack_done = hit & i_cmd.unstack_req;
  end
endmodule

/* File: test/tb.sv */
`timescale 1ns/100ps
module tb
  import eu_pkg::*;
();
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0;
  logic [31:0]  irq = 32'h0;
  logic [31:0]  rdat;
  logic [31:0]  rq;
  logic         ack;
  eu_core_ev_t  tb_ev = '0;
  eu_core_ev_t  core_ev;
  eu_core_cmd_t cmd;
  int           err_count = 0;
  int           check_count = 0;
  logic [31:0]  sw_bit [3] = '{32'h1, 32'h2, 32'h8};
  logic [31:0]  sw_adr [3] = '{32'h8, 32'h38, 32'h3C};

  // 125 MHz processor clock
  always #4 clk = ~clk;

  eu_exc_ctrl i_eu_exc_ctrl (.i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_nmi(1'b0), .i_irq(irq), .i_core(core_ev), .o_core(cmd));
  eu_core_model i_eu_core_model (.i_sys_clk(clk), .i_nrst(nrst), .i_cmd(cmd),
    .i_tb_ev(tb_ev), .o_ev(core_ev));

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function void chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endfunction

  // one classic cycle; the answer is taken at the edge that sees ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    chk("wb_ack", 32'h1, 32'(ack));
    rq = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) end_sim;
  endtask

  // waits for a table read at address a, then checks whether state is pushed with it
  task wait_vec(input logic [31:0] a, input logic stk);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end
    while (!(cmd.fetch_req === 1'b1 && cmd.fetch_addr === a) && n < 60);
    chk("fetch_addr", a, cmd.fetch_addr);
    chk("stack_req", 32'(stk), 32'(cmd.stack_req));
    chk("unstack_req", 32'h0, 32'(cmd.unstack_req));
  endtask

  // handler return once entry has settled
  task ret;
    repeat (8) @(posedge clk);
    tb_ev.exc_return <= 1'b1;
    @(posedge clk);
    tb_ev.exc_return <= 1'b0;
  endtask

  task expect_unstack;
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (cmd.unstack_req !== 1'b1 && n < 60);
    chk("unstack_req", 32'h1, 32'(cmd.unstack_req));
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    chk("load_sp", 32'h1, 32'(cmd.load_sp));
    chk("fetch_addr", 32'h0, cmd.fetch_addr);
    nrst <= 1'b1;
    wait_vec(32'h4, 1'b0);
    repeat (6) @(posedge clk);
    chk("priv_thread", 32'h1, 32'(cmd.priv_thread));
    $display("test reset done");
    wb(1'b0, ADR_PRI0, 32'h0);
    chk("pri0", 32'h0, rq);
    wb(1'b0, ADR_SYSPRI1, 32'h0);
    chk("syspri1", 32'h0, rq);
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, rq);
    wb(1'b1, ADR_PRI0, 32'h00070203);
    wb(1'b0, ADR_PRI0, 32'h0);
    chk("pri0", 32'h00070203, rq);
    wb(1'b1, ADR_ENSET, 32'h3);
    wb(1'b1, ADR_PNDSET, 32'h3);
    wait_vec(32'h44, 1'b1);
    wb(1'b0, ADR_PNDSET, 32'h0);
    chk("pending", 32'h1, rq);
    chk("handler", 32'h1, 32'(cmd.handler));
    ret;
    wait_vec(32'h40, 1'b0);
    ret;
    expect_unstack;
    $display("test priority and tail chain done");
    irq <= 32'h1;
    wait_vec(32'h40, 1'b1);
    ret;
    wait_vec(32'h40, 1'b0);
    irq <= 32'h0;
    wb(1'b1, ADR_PNDCLR, 32'h1);
    ret;
    expect_unstack;
    wb(1'b1, ADR_ENCLR, 32'h3);
    wb(1'b1, ADR_PNDSET, 32'h2);
    repeat (12) @(posedge clk);
    chk("handler", 32'h0, 32'(cmd.handler));
    wb(1'b1, ADR_PNDCLR, 32'h3);
    $display("test peripheral source done");
    tb_ev.supervisor_call <= 1'b1;
    @(posedge clk);
    tb_ev.supervisor_call <= 1'b0;
    wait_vec(32'h2C, 1'b1);
    ret;
    expect_unstack;
    for (int k = 0; k < 3; k++)
    begin
      wb(1'b1, ADR_CTRL, sw_bit[k]);
      wait_vec(sw_adr[k], 1'b1);
      ret;
      expect_unstack;
    end
    $display("test system exceptions done");
    end_sim;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED run_length expected end seen timeout");
    end_sim;
  end
endmodule
